// File: design/scd_pkg.sv
package scd_pkg;

  // oscillator source codes
  localparam logic [2:0] SRC_FRC_POST  = 3'h7;
  localparam logic [2:0] SRC_FRC_DIV16 = 3'h6;
  localparam logic [2:0] SRC_LOW_POWER_INTERNAL_RC_OSC      = 3'h5;
  localparam logic [2:0] SRC_SECONDARY = 3'h4;
  localparam logic [2:0] SRC_PRI_PLL   = 3'h3;
  localparam logic [2:0] SRC_PRI       = 3'h2;
  localparam logic [2:0] SRC_FRC_PLL   = 3'h1;
  localparam logic [2:0] SRC_FRC       = 3'h0;

  // primary oscillator modes
  localparam logic [1:0] PRI_DISABLED  = 2'h3;
  localparam logic [1:0] PRI_HS        = 2'h2;
  localparam logic [1:0] PRI_XT        = 2'h1;
  localparam logic [1:0] PRI_EXT_CLK   = 2'h0;

  // debug channel codes
  localparam logic [1:0] DBG_PAIR1     = 2'h3;
  localparam logic [1:0] DBG_PAIR2     = 2'h2;
  localparam logic [1:0] DBG_PAIR3     = 2'h1;
  localparam logic [1:0] DBG_RESERVED  = 2'h0;

  // watchdog prescale log2 values
  localparam logic [2:0] WDT_PRE_LOG_LONG  = 3'h7;
  localparam logic [2:0] WDT_PRE_LOG_SHORT = 3'h5;

  // power-up timer: 2 ms at code 1, doubling
  localparam int          POWERUP_DELAY_TIMER_BASE_MS  = 2;
  // regulator start-up hold-off
  localparam int          REG_START_NS  = 20000;
  localparam int          CLK_PERIOD_NS = 40;
  localparam int          REG_START_CYC = (REG_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CYC_PER_MS    = 1000000 / CLK_PERIOD_NS;

  // wishbone register byte addresses
  localparam logic [3:0] ADDR_CONFIG   = 4'h0;
  localparam logic [3:0] ADDR_STATUS   = 4'h4;
  localparam logic [3:0] ADDR_WDT_CTRL = 4'h8;

  // config word field positions
  localparam int POS_TWO_SPEED = 0;
  localparam int POS_INIT_OSC  = 1;
  localparam int POS_CKSW_MODE = 4;
  localparam int POS_OSC_OUT   = 6;
  localparam int POS_PRI_MODE  = 7;
  localparam int POS_HW_WDT    = 9;
  localparam int POS_WIN_DIS   = 10;
  localparam int POS_PLL_WAIT  = 11;
  localparam int POS_WDT_PRE   = 12;
  localparam int POS_WDT_POST  = 13;
  localparam int POS_POWERUP_DELAY_TIMER      = 17;
  localparam int POS_DBG_CH    = 20;
  localparam int CFG_WIDTH     = 22;

  // watchdog control register bits
  localparam int POS_SW_WDT    = 0;
  localparam int POS_WDT_CLEAR = 1;

  typedef enum logic [1:0] {
    SCD_HOLD_REG  = 2'b00,
    SCD_HOLD_POWERUP_DELAY_TIMER = 2'b01,
    SCD_RUN       = 2'b10
  } scd_state_type;

endpackage

// File: design/scd_hold_timer.sv
`timescale 1ns/1ps
`default_nettype none
// down counter: loads a count, pulses done when it has counted down to one
module scd_hold_timer #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // control
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] loadValue,
  output logic                  busy,
  output logic                  done
);
  logic [WIDTH-1:0] count_ff;
  logic             busy_ff;
  logic             done_ff;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count_ff <= '0;
      busy_ff  <= 1'b0;
      done_ff  <= 1'b0;
    end else if (load) begin
      count_ff <= loadValue;
      busy_ff  <= 1'b1;
      done_ff  <= 1'b0;
    end else if (busy_ff) begin
      if (count_ff <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
        busy_ff <= 1'b0;
        done_ff <= 1'b1;
      end else begin
        count_ff <= count_ff - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end else begin
      done_ff <= 1'b0;
    end
  end

  assign busy = busy_ff;
  assign done = done_ff;
endmodule
`default_nettype wire

// File: design/scd_startup_config_decode.sv
`timescale 1ns/1ps
`default_nettype none
module scd_startup_config_decode
  import scd_pkg::*;
#(
  parameter int POWERUP_DELAY_TIMER_MS_CYCLES = scd_pkg::CYC_PER_MS
) (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  // non-volatile configuration word
  input  wire logic [scd_pkg::CFG_WIDTH-1:0] configWord,
  // power events
  input  wire logic                        powerResume,
  // oscillator status
  input  wire logic                        selectedOscReady,
  input  wire logic                        pllLocked,
  // watchdog time base from prescaler chain
  input  wire logic                        watchdogTimeout,
  input  wire logic                        watchdogInLastQuarter,
  // wishbone slave
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [3:0]                  wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [31:0]                 wb_dat_i,
  output logic      [31:0]                 wb_dat_o,
  output logic                             wb_ack_o,
  // decoded clock settings
  output logic      [2:0]                  activeOscSource,
  output logic                             clockSwitchAllowed,
  output logic                             failSafeMonitorEn,
  output logic                             pllWaitForLock,
  output logic                             oscOutIsClock,
  output logic      [1:0]                  primaryOscMode,
  // decoded watchdog settings
  output logic                             watchdogRunning,
  output logic                             lowPowerRcOn,
  output logic                             watchdogWindowMode,
  output logic      [2:0]                  watchdogPrescaleLog,
  output logic      [3:0]                  watchdogPostscaleLog,
  output logic                             watchdogResetReq,
  // debug pin routing, one-hot pair 1..3
  output logic      [2:0]                  debugPairSel,
  // start-up gating
  output logic                             codeExecEnable
);
  logic [CFG_WIDTH-1:0] cfg_ff;
  logic                 swWdt_ff;
  logic [2:0]           oscSrc_ff;
  logic                 wdtReset_ff;
  logic                 execEn_ff;
  logic [31:0]          rdData_ff;
  logic                 ack_ff;
  scd_state_type        state_ff;
  scd_state_type        nxt_state;
  logic                 timerLoad;
  logic [31:0]          timerValue;
  logic                 timerDone;
  logic                 timerBusy;

  logic       twoSpeed;
  logic [2:0] initSrc;
  logic [1:0] ckswMode;
  logic       oscOutFn;
  logic [1:0] priMode;
  logic       hwWdt;
  logic       watchdog_window_disable;
  logic       pllWait;
  logic       watchdog_prescale_sel;
  logic [3:0] watchdog_postscale_sel;
  logic [2:0] pwrtSel;
  logic [1:0] dbgCh;
  logic       wbWrite;
  logic       wbRead;
  logic       wbCommit;
  logic       wdtActive;
  logic       srcUsesPll;

  assign twoSpeed   = cfg_ff[POS_TWO_SPEED];
  assign initSrc    = cfg_ff[POS_INIT_OSC +: 3];
  assign ckswMode   = cfg_ff[POS_CKSW_MODE +: 2];
  assign oscOutFn   = cfg_ff[POS_OSC_OUT];
  assign priMode    = cfg_ff[POS_PRI_MODE +: 2];
  assign hwWdt      = cfg_ff[POS_HW_WDT];
  assign watchdog_window_disable     = cfg_ff[POS_WIN_DIS];
  assign pllWait    = cfg_ff[POS_PLL_WAIT];
  assign watchdog_prescale_sel     = cfg_ff[POS_WDT_PRE];
  assign watchdog_postscale_sel    = cfg_ff[POS_WDT_POST +: 4];
  assign pwrtSel    = cfg_ff[POS_POWERUP_DELAY_TIMER +: 3];
  assign dbgCh      = cfg_ff[POS_DBG_CH +: 2];
  assign wbWrite    = wb_cyc_i && wb_stb_i && wb_we_i && !ack_ff;
  assign wbRead     = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_ff;
  // a write lands on the edge that carries ack, as the bus master expects
  assign wbCommit   = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff;
  assign wdtActive  = hwWdt || swWdt_ff;
  assign srcUsesPll = (initSrc == SRC_PRI_PLL) || (initSrc == SRC_FRC_PLL);

  // settings latched while reset is held, frozen once running
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cfg_ff <= configWord;
    end
  end

  // start-up sequence: regulator hold-off, then power-up timer
  always_comb begin
    nxt_state  = state_ff;
    timerLoad  = 1'b0;
    timerValue = 32'h0;
    case (state_ff)
      SCD_HOLD_REG: begin
        if (timerDone) begin
          if (pwrtSel == 3'h0) begin
            nxt_state = SCD_RUN;
          end else begin
            nxt_state  = SCD_HOLD_POWERUP_DELAY_TIMER;
            timerLoad  = 1'b1;
            timerValue = 32'(POWERUP_DELAY_TIMER_BASE_MS * POWERUP_DELAY_TIMER_MS_CYCLES) << (pwrtSel - 3'h1);
          end
        end
      end
      SCD_HOLD_POWERUP_DELAY_TIMER: begin
        if (timerDone) begin
          nxt_state = SCD_RUN;
        end
      end
      SCD_RUN: begin
        if (powerResume) begin
          nxt_state  = SCD_HOLD_REG;
          timerLoad  = 1'b1;
          timerValue = 32'(REG_START_CYC);
        end
      end
      default: begin
        nxt_state = SCD_HOLD_REG;
      end
    endcase
  end

  // reset load of the hold-off comes from the first cycle after release
  logic firstCycle_ff;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_ff      <= SCD_HOLD_REG;
      firstCycle_ff <= 1'b1;
    end else begin
      state_ff      <= nxt_state;
      firstCycle_ff <= 1'b0;
    end
  end

  scd_hold_timer #(
    .WIDTH(32)
  ) u_hold_timer (
    .clk      (clk),
    .reset_n  (reset_n),
    .load     (timerLoad || firstCycle_ff),
    .loadValue(firstCycle_ff ? 32'(REG_START_CYC) : timerValue),
    .busy     (timerBusy),
    .done     (timerDone)
  );

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      execEn_ff <= 1'b0;
    end else begin
      execEn_ff <= (nxt_state == SCD_RUN) && !timerBusy;
    end
  end

  // clock source: fast RC first when two-speed start is on
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      oscSrc_ff <= SRC_FRC;
    end else if (!twoSpeed) begin
      oscSrc_ff <= initSrc;
    end else if (oscSrc_ff != initSrc && selectedOscReady) begin
      // a pll source may need lock before the switch completes
      if (!(srcUsesPll && pllWait && !pllLocked)) begin
        oscSrc_ff <= initSrc;
      end
    end
  end

  // software watchdog enable and window check
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      swWdt_ff    <= 1'b0;
      wdtReset_ff <= 1'b0;
    end else begin
      if (wbCommit && wb_adr_i == ADDR_WDT_CTRL && wb_sel_i[0]) begin
        swWdt_ff <= wb_dat_i[POS_SW_WDT];
      end
      // early clear in window mode or a timeout trips the reset request
      wdtReset_ff <= wdtActive && (watchdogTimeout ||
                     (wbCommit && wb_adr_i == ADDR_WDT_CTRL && wb_sel_i[0] &&
                      wb_dat_i[POS_WDT_CLEAR] && !watchdog_window_disable &&
                      !watchdogInLastQuarter));
    end
  end

  // wishbone: one wait state, unmapped reads return zero
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ack_ff    <= 1'b0;
      rdData_ff <= 32'h0;
    end else begin
      ack_ff <= (wbWrite || wbRead);
      if (wbRead) begin
        case (wb_adr_i)
          ADDR_CONFIG:   rdData_ff <= 32'(cfg_ff);
          ADDR_STATUS:   rdData_ff <= {27'h0, execEn_ff, oscSrc_ff, wdtActive};
          ADDR_WDT_CTRL: rdData_ff <= {31'h0, swWdt_ff};
          default:       rdData_ff <= 32'h0;
        endcase
      end
    end
  end

  // registered decode outputs
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      clockSwitchAllowed   <= 1'b0;
      failSafeMonitorEn    <= 1'b0;
      pllWaitForLock       <= 1'b0;
      oscOutIsClock        <= 1'b0;
      primaryOscMode       <= PRI_DISABLED;
      watchdogRunning      <= 1'b0;
      lowPowerRcOn         <= 1'b0;
      watchdogWindowMode   <= 1'b0;
      watchdogPrescaleLog  <= WDT_PRE_LOG_SHORT;
      watchdogPostscaleLog <= 4'h0;
      debugPairSel         <= 3'h0;
    end else begin
      clockSwitchAllowed   <= !ckswMode[1];
      failSafeMonitorEn    <= (ckswMode == 2'h0);
      pllWaitForLock       <= pllWait;
      // crystal modes own the pin, so the pin setting is ignored there
      oscOutIsClock        <= oscOutFn && priMode != PRI_HS && priMode != PRI_XT;
      primaryOscMode       <= priMode;
      watchdogRunning      <= wdtActive;
      lowPowerRcOn         <= wdtActive;
      watchdogWindowMode   <= !watchdog_window_disable;
      watchdogPrescaleLog  <= watchdog_prescale_sel ? WDT_PRE_LOG_LONG : WDT_PRE_LOG_SHORT;
      watchdogPostscaleLog <= watchdog_postscale_sel;
      case (dbgCh)
        DBG_PAIR1: debugPairSel <= 3'b001;
        DBG_PAIR2: debugPairSel <= 3'b010;
        DBG_PAIR3: debugPairSel <= 3'b100;
        default:   debugPairSel <= 3'b000;
      endcase
    end
  end

  assign activeOscSource  = oscSrc_ff;
  assign watchdogResetReq = wdtReset_ff;
  assign codeExecEnable   = execEn_ff;
  assign wb_dat_o         = rdData_ff;
  assign wb_ack_o         = ack_ff;
endmodule
`default_nettype wire

// File: bench/scd_decode_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module scd_decode_asserts
  import scd_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [21:0] configWord,
  input wire logic        powerResume,
  input wire logic        watchdogTimeout,
  input wire logic        watchdogInLastQuarter,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic [2:0]  activeOscSource,
  input wire logic        clockSwitchAllowed,
  input wire logic        failSafeMonitorEn,
  input wire logic        pllWaitForLock,
  input wire logic        oscOutIsClock,
  input wire logic [1:0]  primaryOscMode,
  input wire logic        watchdogRunning,
  input wire logic        lowPowerRcOn,
  input wire logic        watchdogWindowMode,
  input wire logic [2:0]  watchdogPrescaleLog,
  input wire logic [3:0]  watchdogPostscaleLog,
  input wire logic        watchdogResetReq,
  input wire logic [2:0]  debugPairSel,
  input wire logic        codeExecEnable
);
  localparam int HOLD = REG_START_CYC;
  // own copy of the settings: a pin change after reset then shows as a mismatch
  logic [21:0] cfg;
  int          upCnt;
  always_ff @(posedge clk) begin
    if (!reset_n) cfg <= configWord;
  end
  always_ff @(posedge clk) begin
    if (!reset_n || (powerResume && codeExecEnable)) upCnt <= 0;
    else if (upCnt < HOLD) upCnt <= upCnt + 1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence earlyClear;
    wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == ADDR_WDT_CTRL && wb_dat_i[1]
      && watchdogWindowMode && watchdogRunning && !watchdogInLastQuarter;
  endsequence
  a_switch_mode: assert property ($past(reset_n) |->
    clockSwitchAllowed == !cfg[5] && failSafeMonitorEn == (cfg[5:4] == 2'h0))
    else $error("switch mode decode wrong");
  a_osc_out: assert property ($past(reset_n) |->
    oscOutIsClock == (cfg[6] && cfg[8:7] != PRI_HS && cfg[8:7] != PRI_XT))
    else $error("osc out pin function wrong");
  a_primary_mode: assert property ($past(reset_n) |-> primaryOscMode == cfg[8:7])
    else $error("primary mode wrong");
  a_window_lock: assert property ($past(reset_n) |->
    watchdogWindowMode == !cfg[10] && pllWaitForLock == cfg[11])
    else $error("window or lock wait wrong");
  a_wdt_scaling: assert property ($past(reset_n) |->
    watchdogPrescaleLog == (cfg[12] ? WDT_PRE_LOG_LONG : WDT_PRE_LOG_SHORT)
    && watchdogPostscaleLog == cfg[16:13]) else $error("watchdog scaling wrong");
  a_debug_route: assert property ($past(reset_n) |-> debugPairSel ==
    {cfg[21:20] == DBG_PAIR3, cfg[21:20] == DBG_PAIR2, cfg[21:20] == DBG_PAIR1})
    else $error("debug pair wrong");
  a_direct_boot: assert property ($past(reset_n) && !cfg[0] |->
    activeOscSource == cfg[3:1]) else $error("direct boot source wrong");
  a_boot_frc: assert property ($rose(reset_n) && cfg[0] |=>
    activeOscSource == SRC_FRC) else $error("two-speed boot not on fast rc");
  a_hw_wdt_on: assert property ($past(reset_n) && cfg[9] |->
    watchdogRunning && lowPowerRcOn) else $error("hardware watchdog not running");
  a_sw_cleared: assert property ($rose(reset_n) && !cfg[9] |=> !watchdogRunning)
    else $error("software enable survived reset");
  a_early_clear: assert property (earlyClear |-> ##[0:2] watchdogResetReq)
    else $error("early clear gave no reset");
  a_timeout_req: assert property (watchdogTimeout && watchdogRunning |->
    ##[0:2] watchdogResetReq) else $error("timeout gave no reset");
  a_hold_off: assert property ($rose(codeExecEnable) |-> upCnt >= HOLD - 1)
    else $error("execution enabled too early");
endmodule
bind scd_startup_config_decode scd_decode_asserts asserts_u (.clk, .reset_n, .configWord,
  .powerResume, .watchdogTimeout, .watchdogInLastQuarter, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_i, .wb_ack_o, .activeOscSource, .clockSwitchAllowed,
  .failSafeMonitorEn, .pllWaitForLock, .oscOutIsClock, .primaryOscMode, .watchdogRunning,
  .lowPowerRcOn, .watchdogWindowMode, .watchdogPrescaleLog, .watchdogPostscaleLog,
  .watchdogResetReq, .debugPairSel, .codeExecEnable);
`default_nettype wire

// File: bench/scd_startup_config_decode_tb.sv
`timescale 1ns/1ps
`default_nettype none
module scd_startup_config_decode_tb;
  import scd_pkg::*;
  localparam int MSC = 10;
  logic        clk;
  logic        reset_n;
  logic [21:0] configWord;
  logic        powerResume;
  logic        selectedOscReady;
  logic        pllLocked;
  logic        watchdogTimeout;
  logic        watchdogInLastQuarter;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [3:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [2:0]  activeOscSource;
  logic        watchdogRunning;
  logic        lowPowerRcOn;
  logic        watchdogResetReq;
  logic        codeExecEnable;
  int          error_cnt = 0;
  int          total_checks = 0;
  int          reqCnt = 0;
  scd_startup_config_decode #(.POWERUP_DELAY_TIMER_MS_CYCLES(MSC)) dut_u (.clk, .reset_n, .configWord,
    .powerResume, .selectedOscReady, .pllLocked, .watchdogTimeout, .watchdogInLastQuarter,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .activeOscSource, .clockSwitchAllowed(), .failSafeMonitorEn(), .pllWaitForLock(),
    .oscOutIsClock(), .primaryOscMode(), .watchdogRunning, .lowPowerRcOn,
    .watchdogWindowMode(), .watchdogPrescaleLog(), .watchdogPostscaleLog(),
    .watchdogResetReq, .debugPairSel(), .codeExecEnable);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) if (watchdogResetReq === 1'b1) reqCnt <= reqCnt + 1;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_range(input int got, input int lo, input int hi, input string what);
    total_checks++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("Error at %0t: %s took %0d cycles", $time, what, got);
    end
  endtask
  task automatic wb_acc(input logic we, input logic [3:0] a, input logic [31:0] d,
                        output logic [31:0] q);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    $display("Error at %0t: run hung", $time);
    give_verdict();
  end
  initial begin
    logic [21:0] cfg;
    logic [31:0] q;
    logic [2:0]  b;
    int          cnt;
    int          pw;
    int          e;
    {reset_n, powerResume, selectedOscReady, pllLocked, watchdogTimeout} = '0;
    {watchdogInLastQuarter, wb_cyc_i, wb_stb_i, wb_we_i} = '0;
    {configWord, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hf;
    @(posedge clk);
    // one table walk covers every code of each field but osc out (held at 1) and postscale (8 of 16 codes), across eight resets
    for (int i = 0; i < 8; i++) begin
      b = i[2:0];
      cfg = {b[1:0], b, b, b[0], b[0], b[1], b[2], b[0], b[1:0], 1'b1, b[1:0], b, b[1]};
      pw = (b == 3'h0) ? 0 : (2 << (b - 1)) * MSC;
      configWord <= cfg;
      reset_n <= 1'b0;
      selectedOscReady <= 1'b0;
      pllLocked <= 1'b0;
      repeat (i == 0 ? 12 : 3) @(posedge clk);
      reset_n <= 1'b1;
      cnt = 0;
      do begin
        @(posedge clk);
        cnt++;
        if (cnt == 1) configWord <= ~cfg;
      end while (codeExecEnable !== 1'b1 && cnt < 3000);
      chk_range(cnt, REG_START_CYC + pw, REG_START_CYC + pw + 6, "hold-off");
      chk(32'(activeOscSource), 32'(b[1] ? SRC_FRC : b), "boot source");
      selectedOscReady <= 1'b1;
      repeat (4) @(posedge clk);
      if (b == SRC_PRI_PLL) begin
        chk(32'(activeOscSource), 32'(SRC_FRC), "lock wait");
        pllLocked <= 1'b1;
      end
      cnt = 0;
      while (activeOscSource !== b && cnt < 20) begin
        @(posedge clk);
        cnt++;
      end
      chk(32'(activeOscSource), 32'(b), "final source");
      wb_acc(1'b0, ADDR_WDT_CTRL, '0, q);
      chk(32'(q[0]), 32'h0, "sw enable after reset");
      wb_acc(1'b1, ADDR_CONFIG, '0, q);
      wb_acc(1'b0, ADDR_CONFIG, '0, q);
      chk(q, 32'(cfg), "config readback");
      wb_acc(1'b0, 4'hc, '0, q);
      chk(q, 32'h0, "unmapped read");
      wb_acc(1'b0, ADDR_STATUS, '0, q);
      chk(32'(q[4:0]), 32'({1'b1, b, b[0]}), "status");
      wb_acc(1'b1, ADDR_WDT_CTRL, 32'h1, q);
      repeat (2) @(posedge clk);
      chk(32'({watchdogRunning, lowPowerRcOn}), 32'h3, "sw start");
      e = reqCnt;
      watchdogInLastQuarter <= 1'b1;
      wb_acc(1'b1, ADDR_WDT_CTRL, 32'h3, q);
      watchdogInLastQuarter <= 1'b0;
      wb_acc(1'b1, ADDR_WDT_CTRL, 32'h3, q);
      repeat (3) @(posedge clk);
      chk(32'(reqCnt != e), 32'(!b[2]), "early clear");
      e = reqCnt;
      watchdogTimeout <= 1'b1;
      @(posedge clk);
      watchdogTimeout <= 1'b0;
      repeat (3) @(posedge clk);
      chk(32'(reqCnt != e), 32'h1, "timeout reset");
      wb_acc(1'b1, ADDR_WDT_CTRL, 32'h0, q);
      repeat (2) @(posedge clk);
      chk(32'({watchdogRunning, lowPowerRcOn}), 32'({2{b[0]}}), "sw stop");
      wb_acc(1'b1, ADDR_WDT_CTRL, 32'h1, q);
      powerResume <= 1'b1;
      @(posedge clk);
      powerResume <= 1'b0;
      repeat (3) @(posedge clk);
      chk(32'(codeExecEnable), 32'h0, "resume gate");
      cnt = 4;
      while (codeExecEnable !== 1'b1 && cnt < 3000) begin
        @(posedge clk);
        cnt++;
      end
      chk_range(cnt, REG_START_CYC, REG_START_CYC + pw + 8, "resume hold-off");
      $display("config %0d done", i);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
